// [core/mcm_pkg.sv]
package mcm_pkg;

  // ----------------------------------------------------------------
  // Address and cipher geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 56;
  localparam int KEY_W = 128;
  localparam int KEY_WORDS = 4;
  // Bit 56 in MSB-first numbering of a 64-bit real address, the 128-byte granule.
  localparam int SUBCH_SEL_BIT = 7;
  // Region registers hold address bits [55:24], so regions are 16 MB granules.
  localparam int BAR_LSB = 24;
  localparam int BAR_W = ADDR_W - BAR_LSB;
  localparam int MIX_ROT = 13;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] REG_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] REG_STATUS = 12'h004;
  localparam logic [APB_AW-1:0] REG_MIR_BASE = 12'h008;
  localparam logic [APB_AW-1:0] REG_MIR_SIZE = 12'h00C;
  localparam logic [APB_AW-1:0] REG_CFG_BASE = 12'h010;
  localparam logic [APB_AW-1:0] REG_CFG_SIZE = 12'h014;
  localparam logic [APB_AW-1:0] REG_MMIO_BASE = 12'h018;
  localparam logic [APB_AW-1:0] REG_MMIO_SIZE = 12'h01C;
  localparam logic [APB_AW-1:0] REG_DKEY0 = 12'h020;
  localparam logic [APB_AW-1:0] REG_TKEY0 = 12'h030;

  // Control and status field positions.
  localparam int CTRL_MIRROR_BIT = 0;
  localparam int CTRL_CRYPT_BIT = 1;
  localparam int CTRL_XTS_BIT = 2;
  localparam int CTRL_BOTHPOP_BIT = 3;
  localparam int ST_FUSE_BIT = 0;
  localparam int ST_CRYPT_BIT = 1;
  localparam int ST_RETRY_BIT = 2;
  localparam int ST_RETRYCNT_LSB = 8;
  localparam int ST_BADCNT_LSB = 16;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  // Sub-channel target masks.
  localparam logic [1:0] TGT_A = 2'h1;
  localparam logic [1:0] TGT_B = 2'h2;
  localparam logic [1:0] TGT_BOTH = 2'h3;

  typedef enum logic {
    RT_IDLE,
    RT_PEND
  } mcm_retry_t;

endpackage

// [core/mcm_crypt_pipe.sv]
module mcm_crypt_pipe #(
  parameter int DATA_W = 128,
  parameter int SIDE_W = 8,
  parameter int STAGES = 4
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  input wire logic in_bypass_i,
  input wire logic in_xts_i,
  input wire logic [mcm_pkg::KEY_W-1:0] key_i,
  input wire logic [mcm_pkg::KEY_W-1:0] tweak_i,
  input wire logic [mcm_pkg::ADDR_W-1:0] in_addr_i,
  input wire logic [DATA_W-1:0] in_data_i,
  input wire logic [SIDE_W-1:0] in_side_i,
  output logic out_valid_o,
  output logic [DATA_W-1:0] out_data_o,
  output logic [SIDE_W-1:0] out_side_o
);
  import mcm_pkg::*;

  localparam int REP = DATA_W / KEY_W;

  if (STAGES < 1 || DATA_W % KEY_W != 0 || DATA_W < ADDR_W) begin : g_bad_cfg
    $error("crypt pipe: STAGES must be >= 1 and DATA_W a multiple of the key width");
  end

  logic v_ff [STAGES];
  logic byp_ff [STAGES];
  logic xts_ff [STAGES];
  logic [DATA_W-1:0] d_ff [STAGES];
  logic [DATA_W-1:0] ks_ff [STAGES];
  logic [SIDE_W-1:0] side_ff [STAGES];

  // ----------------------------------------------------------------
  // Keystream round
  // ----------------------------------------------------------------
  // One round per stage folds the key (and the tweak key in XTS) into the stream.
  // The same round serves encrypt and decrypt, since the stream is only XORed.
  function automatic logic [DATA_W-1:0] mix(input logic [DATA_W-1:0] ks, input logic xts);
    logic [DATA_W-1:0] rot;
    rot = {ks[DATA_W-MIX_ROT-1:0], ks[DATA_W-1:DATA_W-MIX_ROT]};
    mix = rot ^ {REP{key_i}} ^ (xts ? {REP{tweak_i}} : '0);
  endfunction

  // First stage seeds the stream from the address so each line has its own stream.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      v_ff[0] <= 1'b0;
    end else begin
      v_ff[0] <= in_valid_i;
    end
    byp_ff[0] <= in_bypass_i;
    xts_ff[0] <= in_xts_i;
    d_ff[0] <= in_data_i;
    side_ff[0] <= in_side_i;
    ks_ff[0] <= mix({{(DATA_W-ADDR_W){1'b0}}, in_addr_i}, in_xts_i);
  end

  // A new item enters every cycle, so throughput never drops with the cipher on.
  for (genvar g = 1; g < STAGES; g++) begin : g_stage
    always_ff @(posedge clock_i) begin
      if (srst_i) begin
        v_ff[g] <= 1'b0;
      end else begin
        v_ff[g] <= v_ff[g-1];
      end
      byp_ff[g] <= byp_ff[g-1];
      xts_ff[g] <= xts_ff[g-1];
      d_ff[g] <= d_ff[g-1];
      side_ff[g] <= side_ff[g-1];
      ks_ff[g] <= mix(ks_ff[g-1], xts_ff[g-1]);
    end
  end

  // Output stage applies the stream to data only; sideband passes in clear.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      out_valid_o <= 1'b0;
    end else begin
      out_valid_o <= v_ff[STAGES-1];
    end
    out_data_o <= byp_ff[STAGES-1] ? d_ff[STAGES-1] : d_ff[STAGES-1] ^ ks_ff[STAGES-1];
    out_side_o <= side_ff[STAGES-1];
  end

endmodule

// [core/mcm_channel.sv]
// How it works
// (RL1) Mirroring pairs sub-channel A with B.
// (RL2) Mirror only addresses inside mirrored region.
// (RL3) Mirrored writes go to both sub-channels.
// (RL4) Mirrored reads pick primary by bit 56.
// (RL5) Failed primary read retries on secondary.
// (RL6) Firmware mirrors only identical, equal halves.
// (RL7) Software keeps mirrored, plain regions disjoint.
// (RL8) Enabled cipher covers all system memory.
// (RL9) Config and MMIO space bypass cipher.
// (RL10) Cipher offers XTS and CTR modes.
// (RL11) Boot firmware chooses the cipher mode.
// (RL12) Cipher pipeline accepts one item per cycle.
// (RL13) Only data encrypted, metadata passes clear.
// (RL14) 128-bit keys held for this pair.
// (RL15) Firmware loads shared or per-pair keys.
// (RL16) Blown fuse forbids encryption forever.
// (RL17) Non-mirrored halves interleave on 128 bytes.
// (RL18) Double failure returns data marked bad.
module mcm_channel #(
  parameter int DATA_W = 128,
  parameter int META_W = 8,
  parameter int TAG_W = 4,
  parameter int STAGES = 4
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [mcm_pkg::APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic one_time_disable_fuse_i,
  input wire logic fab_req_valid_i,
  output logic fab_req_ready_o,
  input wire logic fab_req_write_i,
  input wire logic [mcm_pkg::ADDR_W-1:0] fab_req_addr_i,
  input wire logic [DATA_W-1:0] fab_req_data_i,
  input wire logic [META_W-1:0] fab_req_meta_i,
  input wire logic [TAG_W-1:0] fab_req_tag_i,
  output logic sca_valid_o,
  output logic scb_valid_o,
  output logic sc_write_o,
  output logic [mcm_pkg::ADDR_W-1:0] sc_addr_o,
  output logic [DATA_W-1:0] sc_data_o,
  output logic [META_W-1:0] sc_meta_o,
  output logic [TAG_W-1:0] sc_tag_o,
  input wire logic mem_rsp_valid_i,
  output logic mem_rsp_ready_o,
  input wire logic [TAG_W-1:0] mem_rsp_tag_i,
  input wire logic [DATA_W-1:0] mem_rsp_data_i,
  input wire logic [META_W-1:0] mem_rsp_meta_i,
  input wire logic mem_rsp_err_i,
  output logic fab_rsp_valid_o,
  output logic [DATA_W-1:0] fab_rsp_data_o,
  output logic [META_W-1:0] fab_rsp_meta_o,
  output logic [TAG_W-1:0] fab_rsp_tag_o,
  output logic fab_rsp_bad_o
);
  import mcm_pkg::*;

  localparam int NTAG = 2 ** TAG_W;
  localparam int SIDE_W = 6 + TAG_W + META_W + ADDR_W;
  localparam int RSIDE_W = 1 + TAG_W + META_W;
  localparam int LAT = STAGES + 1;
  localparam int LAT1 = STAGES + 2;

  if (TAG_W < 1 || TAG_W > 8 || META_W < 1) begin : g_bad_cfg
    $error("channel: TAG_W must be 1..8 and META_W at least 1");
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic pready_ff, pslverr_ff, fuse_blown_ff, crypt_active;
  logic mirror_en_ff, crypt_en_ff, xts_ff, both_pop_ff;
  logic [31:0] prdata_ff, rd_data;
  logic [BAR_W-1:0] mir_base_ff, mir_size_ff, cfg_base_ff, cfg_size_ff;
  logic [BAR_W-1:0] mmio_base_ff, mmio_size_ff;
  logic [KEY_WORDS-1:0][31:0] dkey_ff, tkey_ff;
  logic [CNT_W-1:0] retry_cnt_ff, bad_cnt_ff;
  logic rd_hit, key_hit, wr_en;
  mcm_retry_t retry_st_ff, nxt_retry_st;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = strb[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction

  assign key_hit = (paddr_i[APB_AW-1:4] == REG_DKEY0[APB_AW-1:4] ||
                    paddr_i[APB_AW-1:4] == REG_TKEY0[APB_AW-1:4]) && paddr_i[1:0] == 2'h0;
  // The write lands on the edge at which the master sees pready high.
  assign wr_en = psel_i && penable_i && pwrite_i && pready_ff && rd_hit;
  assign crypt_active = crypt_en_ff && !fuse_blown_ff;

  // Read mux; key words are write-only and read as zero so keys never leak.
  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    case (paddr_i)
      REG_CTRL: begin
        rd_data[CTRL_MIRROR_BIT] = mirror_en_ff;
        rd_data[CTRL_CRYPT_BIT] = crypt_en_ff;
        rd_data[CTRL_XTS_BIT] = xts_ff;
        rd_data[CTRL_BOTHPOP_BIT] = both_pop_ff;
      end
      REG_STATUS: begin
        rd_data[ST_FUSE_BIT] = fuse_blown_ff;
        rd_data[ST_CRYPT_BIT] = crypt_active;
        rd_data[ST_RETRY_BIT] = retry_st_ff == RT_PEND;
        rd_data[ST_RETRYCNT_LSB +: CNT_W] = retry_cnt_ff;
        rd_data[ST_BADCNT_LSB +: CNT_W] = bad_cnt_ff;
      end
      REG_MIR_BASE: rd_data = mir_base_ff;
      REG_MIR_SIZE: rd_data = mir_size_ff;
      REG_CFG_BASE: rd_data = cfg_base_ff;
      REG_CFG_SIZE: rd_data = cfg_size_ff;
      REG_MMIO_BASE: rd_data = mmio_base_ff;
      REG_MMIO_SIZE: rd_data = mmio_size_ff;
      default: rd_hit = key_hit;
    endcase
  end

  // Two-cycle access: pready rises one cycle into the access phase.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= REG_RST;
    end else begin
      pready_ff <= psel_i && penable_i && !pready_ff;
      pslverr_ff <= psel_i && penable_i && !pready_ff && !rd_hit;
      prdata_ff <= (psel_i && penable_i && !pready_ff && !pwrite_i) ? rd_data : REG_RST;
    end
  end

  // Mode and region registers.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      {mirror_en_ff, xts_ff, both_pop_ff} <= 3'h0;
      {mir_base_ff, mir_size_ff, cfg_base_ff, cfg_size_ff} <= '0;
      {mmio_base_ff, mmio_size_ff} <= '0;
    end else if (wr_en) begin
      case (paddr_i)
        REG_CTRL: begin
          if (pstrb_i[0]) begin
            mirror_en_ff <= pwdata_i[CTRL_MIRROR_BIT]; // [RL1]
            xts_ff <= pwdata_i[CTRL_XTS_BIT]; // [RL10]
            both_pop_ff <= pwdata_i[CTRL_BOTHPOP_BIT];
          end
        end
        REG_MIR_BASE: mir_base_ff <= merge(mir_base_ff, pwdata_i, pstrb_i);
        REG_MIR_SIZE: mir_size_ff <= merge(mir_size_ff, pwdata_i, pstrb_i);
        REG_CFG_BASE: cfg_base_ff <= merge(cfg_base_ff, pwdata_i, pstrb_i);
        REG_CFG_SIZE: cfg_size_ff <= merge(cfg_size_ff, pwdata_i, pstrb_i);
        REG_MMIO_BASE: mmio_base_ff <= merge(mmio_base_ff, pwdata_i, pstrb_i);
        REG_MMIO_SIZE: mmio_size_ff <= merge(mmio_size_ff, pwdata_i, pstrb_i);
        default: ;
      endcase
    end
  end

  // Fuse is sticky once seen; the enable is refused and dropped while it is blown.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      fuse_blown_ff <= 1'b0;
      crypt_en_ff <= 1'b0;
    end else begin
      fuse_blown_ff <= fuse_blown_ff || one_time_disable_fuse_i;
      if (fuse_blown_ff) begin
        crypt_en_ff <= 1'b0; // [RL16]
      end else if (wr_en && paddr_i == REG_CTRL && pstrb_i[0]) begin
        crypt_en_ff <= pwdata_i[CTRL_CRYPT_BIT];
      end
    end
  end

  // Data and tweak keys, 128 bits each, for this channel's sub-channel pair.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dkey_ff <= '0;
      tkey_ff <= '0;
    end else if (wr_en && key_hit) begin
      if (paddr_i[APB_AW-1:4] == REG_DKEY0[APB_AW-1:4]) begin
        dkey_ff[paddr_i[3:2]] <= merge(dkey_ff[paddr_i[3:2]], pwdata_i, pstrb_i); // [RL14]
      end else begin
        tkey_ff[paddr_i[3:2]] <= merge(tkey_ff[paddr_i[3:2]], pwdata_i, pstrb_i);
      end
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;

  // ----------------------------------------------------------------
  // Request decode and write/read issue
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] ctx_addr [NTAG];
  logic ctx_mir [NTAG];
  logic ctx_byp [NTAG];
  logic ctx_prim_b [NTAG];
  logic ctx_retried [NTAG];
  logic [TAG_W-1:0] retry_tag_ff;
  logic fab_ready_ff, rsp_ready_ff, in_valid, in_retry, in_write, in_mir, in_byp;
  logic cfg_hit, mmio_hit, need_retry, rsp_take;
  logic [1:0] in_tgt;
  logic [ADDR_W-1:0] in_addr;
  logic [TAG_W-1:0] in_tag;
  logic [SIDE_W-1:0] in_side, out_side;
  logic out_valid, o_retry, o_write, o_mir, o_byp;
  logic [1:0] o_tgt;
  logic [TAG_W-1:0] o_tag;
  logic [META_W-1:0] o_meta;
  logic [ADDR_W-1:0] o_addr;
  logic [DATA_W-1:0] out_data;

  function automatic logic in_region(input logic [ADDR_W-1:0] a, input logic [BAR_W-1:0] base,
                                     input logic [BAR_W-1:0] size);
    logic [BAR_W:0] top;
    top = {1'b0, base} + {1'b0, size};
    in_region = ({1'b0, a[ADDR_W-1:BAR_LSB]} >= {1'b0, base}) &&
                ({1'b0, a[ADDR_W-1:BAR_LSB]} < top);
  endfunction

  // A pending retry owns the pipeline input; the fabric ready drops at the same edge.
  assign in_retry = retry_st_ff == RT_PEND;
  assign in_valid = in_retry || (fab_req_valid_i && fab_ready_ff);
  assign in_addr = in_retry ? ctx_addr[retry_tag_ff] : fab_req_addr_i;
  assign in_tag = in_retry ? retry_tag_ff : fab_req_tag_i;
  assign in_write = !in_retry && fab_req_write_i;
  assign cfg_hit = in_region(in_addr, cfg_base_ff, cfg_size_ff);
  assign mmio_hit = in_region(in_addr, mmio_base_ff, mmio_size_ff);
  assign in_mir = mirror_en_ff && in_region(in_addr, mir_base_ff, mir_size_ff); // [RL2]
  assign in_byp = !crypt_active || cfg_hit || mmio_hit; // [RL8] [RL9]

  // Target choice; the pair shares bit 56 for both primary choice and interleave.
  always_comb begin
    if (in_retry) begin
      in_tgt = ctx_prim_b[retry_tag_ff] ? TGT_A : TGT_B; // [RL5]
    end else if (in_mir && in_write) begin
      in_tgt = TGT_BOTH; // [RL3]
    end else if (in_mir || both_pop_ff) begin
      in_tgt = in_addr[SUBCH_SEL_BIT] ? TGT_B : TGT_A; // [RL4] [RL17]
    end else begin
      in_tgt = TGT_A;
    end
  end

  assign in_side = {in_retry, in_write, in_mir, in_byp, in_tgt, in_tag,
                    in_retry ? {META_W{1'b0}} : fab_req_meta_i, in_addr};
  assign {o_retry, o_write, o_mir, o_byp, o_tgt, o_tag, o_meta, o_addr} = out_side;

  // Store-side cipher; metadata rides in the sideband unencrypted.
  mcm_crypt_pipe #(.DATA_W(DATA_W), .SIDE_W(SIDE_W), .STAGES(STAGES)) u_enc (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .in_valid_i(in_valid), // [RL12]
    .in_bypass_i(in_byp || !in_write),
    .in_xts_i(xts_ff),
    .key_i(dkey_ff),
    .tweak_i(tkey_ff),
    .in_addr_i(in_addr),
    .in_data_i(fab_req_data_i),
    .in_side_i(in_side), // [RL13]
    .out_valid_o(out_valid),
    .out_data_o(out_data),
    .out_side_o(out_side)
  );

  // Sub-channel issue register; both halves share the bus, valids pick the target.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sca_valid_o <= 1'b0;
      scb_valid_o <= 1'b0;
    end else begin
      sca_valid_o <= out_valid && o_tgt[0];
      scb_valid_o <= out_valid && o_tgt[1];
    end
    sc_write_o <= o_write;
    sc_addr_o <= o_addr;
    sc_data_o <= out_data;
    sc_meta_o <= o_meta;
    sc_tag_o <= o_tag;
  end

  // Read context per tag, captured when the read is issued.
  always_ff @(posedge clock_i) begin
    if (out_valid && !o_write) begin
      ctx_addr[o_tag] <= o_addr;
      ctx_mir[o_tag] <= o_mir;
      ctx_byp[o_tag] <= o_byp;
      ctx_prim_b[o_tag] <= o_tgt[1];
      ctx_retried[o_tag] <= o_retry;
    end
  end

  // ----------------------------------------------------------------
  // Read return, retry and decrypt
  // ----------------------------------------------------------------
  logic [RSIDE_W-1:0] rsp_side;

  assign rsp_take = mem_rsp_valid_i && rsp_ready_ff;
  assign need_retry = rsp_take && mem_rsp_err_i && ctx_mir[mem_rsp_tag_i] &&
                      !ctx_retried[mem_rsp_tag_i]; // [RL5]

  always_comb begin
    case (retry_st_ff)
      RT_IDLE: nxt_retry_st = need_retry ? RT_PEND : RT_IDLE;
      RT_PEND: nxt_retry_st = RT_IDLE;
      default: nxt_retry_st = RT_IDLE;
    endcase
  end

  // Readies are registered from the next state, so a retry never collides.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      retry_st_ff <= RT_IDLE;
      fab_ready_ff <= 1'b0;
      rsp_ready_ff <= 1'b0;
      retry_tag_ff <= '0;
    end else begin
      retry_st_ff <= nxt_retry_st;
      fab_ready_ff <= nxt_retry_st == RT_IDLE;
      rsp_ready_ff <= nxt_retry_st == RT_IDLE;
      if (need_retry) begin
        retry_tag_ff <= mem_rsp_tag_i;
      end
    end
  end

  // Event counters wrap; they are for health monitoring only.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      retry_cnt_ff <= '0;
      bad_cnt_ff <= '0;
    end else begin
      retry_cnt_ff <= retry_cnt_ff + CNT_W'(need_retry);
      bad_cnt_ff <= bad_cnt_ff + CNT_W'(rsp_take && mem_rsp_err_i && !need_retry);
    end
  end

  assign fab_req_ready_o = fab_ready_ff;
  assign mem_rsp_ready_o = rsp_ready_ff;
  assign rsp_side = {mem_rsp_err_i, mem_rsp_tag_i, mem_rsp_meta_i}; // [RL18]

  // Fetch-side cipher, same depth as the store side.
  mcm_crypt_pipe #(.DATA_W(DATA_W), .SIDE_W(RSIDE_W), .STAGES(STAGES)) u_dec (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .in_valid_i(rsp_take && !need_retry),
    .in_bypass_i(ctx_byp[mem_rsp_tag_i]),
    .in_xts_i(xts_ff),
    .key_i(dkey_ff),
    .tweak_i(tkey_ff),
    .in_addr_i(ctx_addr[mem_rsp_tag_i]),
    .in_data_i(mem_rsp_data_i),
    .in_side_i(rsp_side),
    .out_valid_o(fab_rsp_valid_o),
    .out_data_o(fab_rsp_data_o),
    .out_side_o({fab_rsp_bad_o, fab_rsp_tag_o, fab_rsp_meta_o})
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  property p_wr_both;
    out_valid && o_write && o_mir |=> sca_valid_o && scb_valid_o && sc_write_o;
  endproperty
  a_wr_both: assert property (p_wr_both) else $error("mirrored write not on both"); // [RL3]

  property p_rd_primary;
    out_valid && !o_write && o_mir && !o_retry |=>
      (sc_addr_o[SUBCH_SEL_BIT] ? (scb_valid_o && !sca_valid_o) : (sca_valid_o && !scb_valid_o));
  endproperty
  a_rd_primary: assert property (p_rd_primary) else $error("wrong primary"); // [RL4]

  property p_retry_stall;
    need_retry |=> in_retry && !fab_req_ready_o && !mem_rsp_ready_o ##1 !in_retry;
  endproperty
  a_retry_stall: assert property (p_retry_stall) else $error("retry not inserted"); // [RL5]

  property p_retry_other;
    out_valid && o_retry |=> (sca_valid_o != scb_valid_o) && !sc_write_o;
  endproperty
  a_retry_other: assert property (p_retry_other) else $error("retry not single"); // [RL5]

  // Bypassed store data must reach the sub-channel bus unchanged, not just be flagged.
  property p_bypass;
    in_valid && in_write && (cfg_hit || mmio_hit || !crypt_en_ff || fuse_blown_ff) |-> ##LAT1
      sc_data_o == $past(fab_req_data_i, LAT1);
  endproperty
  a_bypass: assert property (p_bypass) else $error("cipher not bypassed"); // [RL9]

  property p_fuse;
    fuse_blown_ff |=> !crypt_en_ff;
  endproperty
  a_fuse: assert property (p_fuse) else $error("crypt enabled after fuse"); // [RL16]

  property p_meta_clear;
    rsp_take && !need_retry |-> ##LAT fab_rsp_valid_o &&
      fab_rsp_meta_o == $past(mem_rsp_meta_i, LAT);
  endproperty
  a_meta_clear: assert property (p_meta_clear) else $error("metadata altered"); // [RL13]

  property p_double_bad;
    rsp_take && mem_rsp_err_i && ctx_retried[mem_rsp_tag_i] |-> ##LAT fab_rsp_bad_o;
  endproperty
  a_double_bad: assert property (p_double_bad) else $error("double fail not bad"); // [RL18]

  property p_throughput;
    fab_req_valid_i && fab_req_ready_o |-> ##LAT1 (sca_valid_o || scb_valid_o);
  endproperty
  a_throughput: assert property (p_throughput) else $error("request lost in pipe"); // [RL12]

  property p_interleave;
    out_valid && !o_mir && both_pop_ff && !o_retry |=>
      scb_valid_o == sc_addr_o[SUBCH_SEL_BIT];
  endproperty
  a_interleave: assert property (p_interleave) else $error("interleave wrong"); // [RL17]

  c_retry: cover property (need_retry ##[1:20] out_valid && o_retry);
  c_double: cover property (rsp_take && mem_rsp_err_i && ctx_retried[mem_rsp_tag_i]);
  c_mir_wr: cover property (sca_valid_o && scb_valid_o && sc_write_o);
  c_crypt: cover property (in_valid && !in_byp && in_write);

endmodule

// [tb/mcm_mem_model.sv]
module mcm_mem_model #(
  parameter int DW = 128,
  parameter int MW = 8
) (
  input wire logic clock_i,
  input wire logic a_valid_i,
  input wire logic b_valid_i,
  input wire logic write_i,
  input wire logic [55:0] addr_i,
  input wire logic [DW-1:0] data_i,
  input wire logic [MW-1:0] meta_i,
  input wire logic [3:0] tag_i,
  input wire logic err_a_i,
  input wire logic err_b_i,
  input wire logic rsp_ready_i,
  output logic rsp_valid_o = 1'b0,
  output logic [3:0] rsp_tag_o,
  output logic [DW-1:0] rsp_data_o,
  output logic [MW-1:0] rsp_meta_o,
  output logic rsp_err_o
);
  // Both halves are alike in kind and size, so mirroring them is allowed.
  logic [MW+DW-1:0] mem_a [logic [55:0]];
  logic [MW+DW-1:0] mem_b [logic [55:0]];

  // A read answers one edge later and stands until taken; released data flips.
  always @(posedge clock_i) begin
    if (rsp_valid_o && rsp_ready_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= ~rsp_data_o;
    end
    if (a_valid_i && write_i) mem_a[addr_i] = {meta_i, data_i};
    if (b_valid_i && write_i) mem_b[addr_i] = {meta_i, data_i};
    if ((a_valid_i || b_valid_i) && !write_i) begin
      {rsp_meta_o, rsp_data_o} <= a_valid_i ? mem_a[addr_i] : mem_b[addr_i];
      rsp_err_o <= a_valid_i ? err_a_i : err_b_i;
      rsp_tag_o <= tag_i;
      rsp_valid_o <= 1'b1;
    end
  end
endmodule

// [tb/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mcm_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, fuse = 0, rv = 0, rw = 0, ea = 0, eb = 0;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd, prv;
  logic [55:0] ra = 0, sa;
  logic [127:0] rd = 0, sd, md, fd, isd;
  logic [7:0] sm, mm, ism, fm;
  logic [3:0] rt = 0, st, mt, ft;
  logic [1:0] iss;
  logic prdy, perr, pev, rrdy, av, bv, scw, mv, mrdy, me, fv, fb;
  int error_cnt = 0, compares = 0;

  // Clock of 40 ns period.
  always #20 clk = ~clk;

  mcm_channel u_mcm_channel (.clock_i(clk), .srst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(4'hF), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .one_time_disable_fuse_i(fuse), .fab_req_valid_i(rv),
    .fab_req_ready_o(rrdy), .fab_req_write_i(rw), .fab_req_addr_i(ra), .fab_req_data_i(rd),
    .fab_req_meta_i(8'hA5), .fab_req_tag_i(rt), .sca_valid_o(av), .scb_valid_o(bv),
    .sc_write_o(scw), .sc_addr_o(sa), .sc_data_o(sd), .sc_meta_o(sm), .sc_tag_o(st),
    .mem_rsp_valid_i(mv), .mem_rsp_ready_o(mrdy), .mem_rsp_tag_i(mt), .mem_rsp_data_i(md),
    .mem_rsp_meta_i(mm), .mem_rsp_err_i(me), .fab_rsp_valid_o(fv), .fab_rsp_data_o(fd),
    .fab_rsp_meta_o(fm), .fab_rsp_tag_o(ft), .fab_rsp_bad_o(fb));

  mcm_mem_model u_mcm_mem_model (.clock_i(clk), .a_valid_i(av), .b_valid_i(bv),
    .write_i(scw), .addr_i(sa), .data_i(sd), .meta_i(sm), .tag_i(st), .err_a_i(ea),
    .err_b_i(eb), .rsp_ready_i(mrdy), .rsp_valid_o(mv), .rsp_tag_o(mt), .rsp_data_o(md),
    .rsp_meta_o(mm), .rsp_err_o(me));

  // Counts every comparison and reports a mismatch at once.
  task chk(input logic [127:0] got, input logic [127:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask

  task tally_and_finish;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One APB transfer; the request holds until pready is seen at an edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    prv = prd;
    pev = perr;
    psel <= 0;
    pen <= 0;
  endtask

  // One fabric request; the issue pulse stands after the fifth edge past the take.
  task req(input logic w, input logic [55:0] a, input logic [127:0] d);
    @(posedge clk);
    rv <= 1;
    rw <= w;
    ra <= a;
    rd <= d;
    rt <= rt + 4'h1;
    do @(posedge clk); while (rrdy !== 1'b1);
    rv <= 0;
    rd <= ~d;
    repeat (5) @(posedge clk);
    #1;
    iss = {bv, av};
    isd = sd;
    ism = sm;
  endtask

  // Waits a bounded time for the read answer on the fabric side.
  task rsp;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (fv !== 1'b1 && n < 40);
    chk(fv, 1, "no answer");
    chk({ft, fm}, {rt, 8'hA5}, "tag meta");
  endtask

  task t_regs;
    apb(0, REG_CTRL, 0);
    chk(prv, REG_RST, "ctrl reset");
    apb(0, 12'h0F0, 0);
    chk(pev, 1, "unmapped");
    apb(1, REG_MIR_BASE, 1);
    apb(1, REG_MIR_SIZE, 1);
    apb(1, REG_CTRL, 9);
    apb(0, REG_CTRL, 0);
    chk(prv, 9, "ctrl");
  endtask

  task t_mirror;
    req(1, 56'h100_0080, 128'hD1);
    chk(iss, TGT_BOTH, "mirror wr");
    req(1, 56'h100_0000, 128'hD2);
    req(0, 56'h100_0080, 0);
    chk(iss, TGT_B, "primary");
    rsp;
    chk(fd, 128'hD1, "rd data");
    req(0, 56'h100_0000, 0);
    chk(iss, TGT_A, "primary");
    rsp;
    chk(fd, 128'hD2, "rd data");
  endtask

  task t_retry;
    eb <= 1;
    req(0, 56'h100_0080, 0);
    rsp;
    chk({fb, fd}, {1'b0, 128'hD1}, "retry");
    ea <= 1;
    req(0, 56'h100_0080, 0);
    rsp;
    chk(fb, 1, "double fail");
    ea <= 0;
    eb <= 0;
  endtask

  task t_plain;
    req(1, 56'h200_0080, 128'hD5);
    chk(iss, TGT_B, "plain odd");
    req(1, 56'h200_0000, 128'hD5);
    chk(iss, TGT_A, "plain even");
  endtask

  // Both cipher modes, a round trip each, plus a config-space bypass.
  task t_crypt;
    apb(1, REG_DKEY0, 32'h1234_5678);
    apb(1, REG_CFG_BASE, 3);
    apb(1, REG_CFG_SIZE, 1);
    for (int m = 0; m < 2; m++) begin
      apb(1, REG_CTRL, 11 + 4 * m);
      req(1, 56'h100_0100, 128'hD3);
      chk(isd == 128'hD3, 0, "clear text");
      chk(ism, 8'hA5, "meta");
      req(0, 56'h100_0100, 0);
      rsp;
      chk(fd, 128'hD3, "decrypt");
      req(1, 56'h300_0000, 128'hD3);
      chk(isd, 128'hD3, "cfg");
    end
    apb(1, REG_MMIO_BASE, 4);
    apb(1, REG_MMIO_SIZE, 1);
    req(1, 56'h400_0000, 128'hD6);
    chk(isd, 128'hD6, "mmio");
  endtask

  task t_fuse;
    @(posedge clk);
    fuse <= 1;
    apb(1, REG_CTRL, 11);
    apb(0, REG_CTRL, 0);
    chk(prv[1], 0, "locked");
    fuse <= 0;
    apb(1, REG_CTRL, 11);
    apb(0, REG_STATUS, 0);
    chk(prv[1:0], 2'h1, "sticky");
    req(1, 56'h100_0100, 128'hD4);
    chk(isd, 128'hD4, "cipher");
  endtask

  // Main sequence after ten cycles of reset.
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    t_regs;
    t_mirror;
    t_retry;
    t_plain;
    t_crypt;
    t_fuse;
    tally_and_finish;
  end

  // Cuts a hang short well beyond the expected run of some 250 cycles.
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish;
  end
endmodule
